// ### rtl/ptb_top.sv
// Pager translation buffer with refill sequencer and AXI4-Lite registers
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module ptb_top (
	input wire logic sys_clk,
	input wire logic resetn,
	// AXI4-Lite slave
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic irq,
	// Translation request from the execution unit
	input wire logic lk_valid,
	output logic lk_ready,
	input wire logic lk_user,
	input wire logic lk_write,
	input wire logic [ptb_pkg::SECT_W-1:0] lk_section,
	input wire logic [ptb_pkg::VPAGE_W-1:0] lk_page,
	output logic xl_done,
	output logic xl_fail,
	output logic [1:0] xl_fail_code,
	output logic [ptb_pkg::PAGE_W-1:0] xl_ppn,
	output logic xl_keep,
	output logic xl_writable,
	// Pager context load command
	input wire logic ctx_valid,
	output logic ctx_ready,
	input wire logic [ptb_pkg::WORD_W-1:0] ctx_word,
	output logic [2:0] cur_block,
	output logic [2:0] prev_block,
	output logic [ptb_pkg::SECT_W-1:0] prev_section,
	output logic [ptb_pkg::PAGE_W-1:0] process_map_base,
	output logic acct_update,
	// Memory read port for refill
	output logic mem_req,
	output logic [ptb_pkg::PADDR_W-1:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [ptb_pkg::WORD_W-1:0] mem_rdata
);
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic [ptb_pkg::PAGE_W-1:0] exec_base;
		logic [ptb_pkg::PAGE_W-1:0] stat_base;
		logic [ptb_pkg::IRQ_W-1:0] irq_stat;
		logic [ptb_pkg::IRQ_W-1:0] irq_mask;
		logic irq;
		ptb_pkg::ptb_state_e fsm;
		logic req_user;
		logic req_write;
		logic [ptb_pkg::SECT_W-1:0] req_sect;
		logic [ptb_pkg::VPAGE_W-1:0] req_page;
		logic acc_w;
		logic acc_k;
		logic [ptb_pkg::PAGE_W-1:0] map_page;
		logic [ptb_pkg::PAGE_W-1:0] ppn;
		logic mem_req;
		logic [ptb_pkg::PADDR_W-1:0] mem_addr;
		logic lk_ready;
		logic ctx_ready;
		logic xl_done;
		logic xl_fail;
		logic [1:0] fail_code;
		logic [ptb_pkg::PAGE_W-1:0] xl_ppn;
		logic xl_keep;
		logic xl_wr;
		logic [ptb_pkg::ENTRIES-1:0] least_recent_refill_flag;
		logic [2:0] cur_block;
		logic [2:0] prev_block;
		logic [ptb_pkg::SECT_W-1:0] prev_sect;
		logic [ptb_pkg::PAGE_W-1:0] pmb;
		logic acct_upd;
	} ptb_top_s;

	ptb_top_s r_ff;
	ptb_top_s nxt_r;

	logic ctx_take;
	logic lk_take;
	logic fill_en;
	logic fill_way;
	logic sweep_all;
	logic sweep_nk;
	logic [ptb_pkg::IDX_W-1:0] lk_idx;
	logic [ptb_pkg::TAG_W-1:0] lk_tag;
	logic [ptb_pkg::IDX_W-1:0] fill_idx;
	logic [ptb_pkg::TAG_W-1:0] fill_tag;
	logic [ptb_pkg::WAYS-1:0] w_hit;
	logic [ptb_pkg::WAYS-1:0] w_keep;
	logic [ptb_pkg::WAYS-1:0] w_wr;
	logic [ptb_pkg::PAGE_W-1:0] w_ppn [ptb_pkg::WAYS];

	// Context load wins over a lookup offered in the same cycle
	assign ctx_take = ctx_valid && r_ff.ctx_ready;
	assign lk_take = lk_valid && r_ff.lk_ready && !ctx_take;
	assign sweep_all = ctx_take && !ctx_word[ptb_pkg::CTX_KEEP_SWEEP];
	assign sweep_nk = ctx_take && ctx_word[ptb_pkg::CTX_KEEP_SWEEP];

	// Index from the low page bits, tag from user, section and upper page bits
	assign lk_idx = lk_page[ptb_pkg::IDX_W-1:0];
	assign lk_tag = {lk_user, lk_section, lk_page[ptb_pkg::VPAGE_W-1:ptb_pkg::IDX_W]};
	assign fill_idx = r_ff.req_page[ptb_pkg::IDX_W-1:0];
	assign fill_tag = {r_ff.req_user, r_ff.req_sect,
		r_ff.req_page[ptb_pkg::VPAGE_W-1:ptb_pkg::IDX_W]};
	assign fill_en = (r_ff.fsm == ptb_pkg::ST_FILL);
	assign fill_way = r_ff.least_recent_refill_flag[fill_idx];

	// Two ways so one page number may live in two sections at once
	for (genvar g = 0; g < ptb_pkg::WAYS; g++) begin : g_way
		ptb_way u_way (
			.sys_clk(sys_clk),
			.resetn(resetn),
			.lk_index(lk_idx),
			.lk_tag(lk_tag),
			.hit(w_hit[g]),
			.hit_ppn(w_ppn[g]),
			.hit_keep(w_keep[g]),
			.hit_wr(w_wr[g]),
			.wr_en(fill_en && (fill_way == 1'(g))),
			.wr_index(fill_idx),
			.wr_tag(fill_tag),
			.wr_ppn(r_ff.ppn),
			.wr_keep(r_ff.acc_k),
			.wr_wr(r_ff.acc_w),
			.sweep_all(sweep_all),
			.sweep_nonkeep(sweep_nk)
		);
	end

	// Byte-lane merge for read-write registers
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// Next-state logic: bus slave, refill sequencer, context load, interrupts
	always_comb begin
		logic [ptb_pkg::IRQ_W-1:0] w1c;
		logic [ptb_pkg::IRQ_W-1:0] irq_set;
		logic [31:0] wv;
		logic fail_now;
		logic [1:0] fail_c;
		logic [ptb_pkg::WORD_W-1:0] md;
		w1c = '0;
		irq_set = '0;
		wv = '0;
		fail_now = 1'b0;
		fail_c = ptb_pkg::FAIL_SECT;
		md = mem_rdata;
		nxt_r = r_ff;
		nxt_r.xl_done = 1'b0;
		nxt_r.acct_upd = 1'b0;

		// Write address and data may arrive in either order
		if (s_axi_awvalid && r_ff.awready) begin
			nxt_r.aw_have = 1'b1;
			nxt_r.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && r_ff.wready) begin
			nxt_r.w_have = 1'b1;
			nxt_r.w_data = s_axi_wdata;
			nxt_r.w_strb = s_axi_wstrb;
		end
		if (r_ff.bvalid && s_axi_bready) begin
			nxt_r.bvalid = 1'b0;
		end
		if (r_ff.aw_have && r_ff.w_have && !r_ff.bvalid) begin
			nxt_r.aw_have = 1'b0;
			nxt_r.w_have = 1'b0;
			nxt_r.bvalid = 1'b1;
			nxt_r.bresp = ptb_pkg::RESP_OKAY;
			case (r_ff.aw_addr)
				ptb_pkg::REG_EXEC_BASE: begin
					wv = merge(32'(r_ff.exec_base), r_ff.w_data, r_ff.w_strb);
					nxt_r.exec_base = wv[ptb_pkg::PAGE_W-1:0];
				end
				ptb_pkg::REG_STAT_BASE: begin
					wv = merge(32'(r_ff.stat_base), r_ff.w_data, r_ff.w_strb);
					nxt_r.stat_base = wv[ptb_pkg::PAGE_W-1:0];
				end
				ptb_pkg::REG_IRQ_STATUS: begin
					if (r_ff.w_strb[0]) begin
						w1c = r_ff.w_data[ptb_pkg::IRQ_W-1:0];
					end
				end
				ptb_pkg::REG_IRQ_MASK: begin
					wv = merge(32'(r_ff.irq_mask), r_ff.w_data, r_ff.w_strb);
					nxt_r.irq_mask = wv[ptb_pkg::IRQ_W-1:0];
				end
				ptb_pkg::REG_STATE, ptb_pkg::REG_REFILL_AGE: begin
					nxt_r.bresp = ptb_pkg::RESP_OKAY;
				end
				default: begin
					nxt_r.bresp = ptb_pkg::RESP_SLVERR;
				end
			endcase
		end
		// One outstanding write: no new address or data until the response goes
		nxt_r.awready = !nxt_r.aw_have && !nxt_r.bvalid;
		nxt_r.wready = !nxt_r.w_have && !nxt_r.bvalid;

		// Read channel, one beat in flight
		if (r_ff.rvalid && s_axi_rready) begin
			nxt_r.rvalid = 1'b0;
		end
		if (s_axi_arvalid && r_ff.arready) begin
			nxt_r.rvalid = 1'b1;
			nxt_r.rresp = ptb_pkg::RESP_OKAY;
			case (s_axi_araddr)
				ptb_pkg::REG_EXEC_BASE: nxt_r.rdata = 32'(r_ff.exec_base);
				ptb_pkg::REG_STAT_BASE: nxt_r.rdata = 32'(r_ff.stat_base);
				ptb_pkg::REG_IRQ_STATUS: nxt_r.rdata = 32'(r_ff.irq_stat);
				ptb_pkg::REG_IRQ_MASK: nxt_r.rdata = 32'(r_ff.irq_mask);
				ptb_pkg::REG_STATE: nxt_r.rdata = {11'h000, r_ff.pmb, 3'h0,
					r_ff.fail_code, r_ff.fsm};
				ptb_pkg::REG_REFILL_AGE: nxt_r.rdata = 32'(r_ff.least_recent_refill_flag);
				default: begin
					nxt_r.rdata = 32'h0000_0000;
					nxt_r.rresp = ptb_pkg::RESP_SLVERR;
				end
			endcase
		end
		nxt_r.arready = !nxt_r.rvalid;

		// Refill sequencer
		case (r_ff.fsm)
			ptb_pkg::ST_IDLE: begin
				if (ctx_take) begin
					if (ctx_word[ptb_pkg::CTX_SEL_BLK]) begin
						nxt_r.cur_block = ctx_word[ptb_pkg::CTX_CUR_HI:ptb_pkg::CTX_CUR_LO];
						nxt_r.prev_block = ctx_word[ptb_pkg::CTX_PREV_HI:ptb_pkg::CTX_PREV_LO];
					end
					if (ctx_word[ptb_pkg::CTX_SEL_PSECT]) begin
						nxt_r.prev_sect = ctx_word[ptb_pkg::CTX_PSECT_HI:ptb_pkg::CTX_PSECT_LO];
					end
					if (ctx_word[ptb_pkg::CTX_LOAD_BASE]) begin
						nxt_r.pmb = ctx_word[ptb_pkg::CTX_BASE_HI:ptb_pkg::CTX_BASE_LO];
					end
					// Recency flags are untouched by either sweep
					nxt_r.acct_upd = !ctx_word[ptb_pkg::CTX_NO_ACCT];
					irq_set[ptb_pkg::IRQ_CTX] = 1'b1;
				end else if (lk_take) begin
					nxt_r.req_user = lk_user;
					nxt_r.req_write = lk_write;
					nxt_r.req_sect = lk_section;
					nxt_r.req_page = lk_page;
					if (|w_hit) begin
						// Way 0 is preferred; both cannot legally hold one tag
						nxt_r.xl_done = 1'b1;
						nxt_r.xl_ppn = w_hit[0] ? w_ppn[0] : w_ppn[1];
						nxt_r.xl_keep = w_hit[0] ? w_keep[0] : w_keep[1];
						nxt_r.xl_wr = w_hit[0] ? w_wr[0] : w_wr[1];
						nxt_r.xl_fail = lk_write && !nxt_r.xl_wr;
						if (nxt_r.xl_fail) begin
							nxt_r.fail_code = ptb_pkg::FAIL_WPROT;
							irq_set[ptb_pkg::IRQ_FAIL] = 1'b1;
						end
					end else begin
						nxt_r.fsm = ptb_pkg::ST_SECT;
						nxt_r.mem_req = 1'b1;
						nxt_r.mem_addr = {lk_user ? r_ff.pmb : r_ff.exec_base,
							ptb_pkg::SECT_PTR_BASE + 9'(lk_section)};
					end
				end
			end
			ptb_pkg::ST_SECT: begin
				if (mem_ack) begin
					if (!md[ptb_pkg::PTR_PRESENT]) begin
						fail_now = 1'b1;
						fail_c = ptb_pkg::FAIL_SECT;
					end else begin
						nxt_r.acc_w = md[ptb_pkg::PTR_WRITABLE];
						nxt_r.acc_k = md[ptb_pkg::PTR_KEEP];
						nxt_r.map_page = md[ptb_pkg::PTR_PAGE_HI:ptb_pkg::PTR_PAGE_LO];
						nxt_r.mem_addr = {md[ptb_pkg::PTR_PAGE_HI:ptb_pkg::PTR_PAGE_LO],
							r_ff.req_page};
						nxt_r.fsm = ptb_pkg::ST_MAP;
					end
				end
			end
			ptb_pkg::ST_MAP: begin
				if (mem_ack) begin
					if (!md[ptb_pkg::PTR_PRESENT]) begin
						fail_now = 1'b1;
						fail_c = ptb_pkg::FAIL_MAP;
					end else begin
						// Access bits are ANDed across every pointer walked
						nxt_r.acc_w = r_ff.acc_w && md[ptb_pkg::PTR_WRITABLE];
						nxt_r.acc_k = r_ff.acc_k && md[ptb_pkg::PTR_KEEP];
						nxt_r.ppn = md[ptb_pkg::PTR_PAGE_HI:ptb_pkg::PTR_PAGE_LO];
						nxt_r.mem_addr = {r_ff.stat_base, r_ff.map_page[ptb_pkg::VPAGE_W-1:0]};
						nxt_r.fsm = ptb_pkg::ST_STAT;
					end
				end
			end
			ptb_pkg::ST_STAT: begin
				if (mem_ack) begin
					nxt_r.mem_req = 1'b0;
					if (!md[ptb_pkg::PTR_PRESENT]) begin
						fail_now = 1'b1;
						fail_c = ptb_pkg::FAIL_STAT;
					end else if (r_ff.req_write && !r_ff.acc_w) begin
						fail_now = 1'b1;
						fail_c = ptb_pkg::FAIL_WPROT;
					end else begin
						nxt_r.fsm = ptb_pkg::ST_FILL;
					end
				end
			end
			ptb_pkg::ST_FILL: begin
				// Ways write this cycle; the written way becomes most recent
				nxt_r.least_recent_refill_flag[fill_idx] = !fill_way;
				nxt_r.xl_done = 1'b1;
				nxt_r.xl_fail = 1'b0;
				nxt_r.xl_ppn = r_ff.ppn;
				nxt_r.xl_keep = r_ff.acc_k;
				nxt_r.xl_wr = r_ff.acc_w;
				irq_set[ptb_pkg::IRQ_REFILL] = 1'b1;
				nxt_r.fsm = ptb_pkg::ST_IDLE;
			end
			default: begin
				nxt_r.fsm = ptb_pkg::ST_IDLE;
				nxt_r.mem_req = 1'b0;
			end
		endcase

		// Soft page failure aborts the walk and returns to idle
		if (fail_now) begin
			nxt_r.mem_req = 1'b0;
			nxt_r.xl_done = 1'b1;
			nxt_r.xl_fail = 1'b1;
			nxt_r.fail_code = fail_c;
			nxt_r.xl_keep = 1'b0;
			nxt_r.xl_wr = 1'b0;
			irq_set[ptb_pkg::IRQ_FAIL] = 1'b1;
			nxt_r.fsm = ptb_pkg::ST_IDLE;
		end
		nxt_r.lk_ready = (nxt_r.fsm == ptb_pkg::ST_IDLE);
		nxt_r.ctx_ready = (nxt_r.fsm == ptb_pkg::ST_IDLE);

		// Set beats clear so no event is lost
		nxt_r.irq_stat = (r_ff.irq_stat & ~w1c) | irq_set;
		nxt_r.irq = |(nxt_r.irq_stat & nxt_r.irq_mask);
	end

	// State register
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// Outputs straight from flops
	assign s_axi_awready = r_ff.awready;
	assign s_axi_wready = r_ff.wready;
	assign s_axi_bvalid = r_ff.bvalid;
	assign s_axi_bresp = r_ff.bresp;
	assign s_axi_arready = r_ff.arready;
	assign s_axi_rvalid = r_ff.rvalid;
	assign s_axi_rdata = r_ff.rdata;
	assign s_axi_rresp = r_ff.rresp;
	assign irq = r_ff.irq;
	assign lk_ready = r_ff.lk_ready;
	assign xl_done = r_ff.xl_done;
	assign xl_fail = r_ff.xl_fail;
	assign xl_fail_code = r_ff.fail_code;
	assign xl_ppn = r_ff.xl_ppn;
	assign xl_keep = r_ff.xl_keep;
	assign xl_writable = r_ff.xl_wr;
	assign ctx_ready = r_ff.ctx_ready;
	assign cur_block = r_ff.cur_block;
	assign prev_block = r_ff.prev_block;
	assign prev_section = r_ff.prev_sect;
	assign process_map_base = r_ff.pmb;
	assign acct_update = r_ff.acct_upd;
	assign mem_req = r_ff.mem_req;
	assign mem_addr = r_ff.mem_addr;
endmodule
`default_nettype wire

// ### rtl/ptb_pkg.sv
// Shared constants and types of the paged translation buffer
package ptb_pkg;
	// Command and pointer words number bit 00 as the most significant of 36
	localparam int WORD_W = 36;
	localparam int PAGE_W = 13;
	localparam int VPAGE_W = 9;
	localparam int SECT_W = 5;
	localparam int PADDR_W = 22;
	localparam int IDX_W = 5;
	localparam int ENTRIES = 32;
	localparam int TAG_W = 10;
	localparam int WAYS = 2;

	// Context-load word fields, positions in [35:0]
	localparam int CTX_SEL_BLK = 35;
	localparam int CTX_SEL_PSECT = 34;
	localparam int CTX_LOAD_BASE = 33;
	localparam int CTX_KEEP_SWEEP = 32;
	localparam int CTX_CUR_HI = 29;
	localparam int CTX_CUR_LO = 27;
	localparam int CTX_PREV_HI = 26;
	localparam int CTX_PREV_LO = 24;
	localparam int CTX_PSECT_HI = 22;
	localparam int CTX_PSECT_LO = 18;
	localparam int CTX_NO_ACCT = 17;
	localparam int CTX_BASE_HI = 12;
	localparam int CTX_BASE_LO = 0;

	// Section, map pointer and status word fields
	localparam int PTR_PRESENT = 34;
	localparam int PTR_WRITABLE = 32;
	localparam int PTR_KEEP = 30;
	localparam int PTR_PAGE_HI = 12;
	localparam int PTR_PAGE_LO = 0;

	// Word offset of section 0 pointer inside a process table
	localparam logic [8:0] SECT_PTR_BASE = 9'h160;

	// Register byte offsets
	localparam logic [7:0] REG_EXEC_BASE = 8'h00;
	localparam logic [7:0] REG_STAT_BASE = 8'h04;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
	localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
	localparam logic [7:0] REG_STATE = 8'h10;
	localparam logic [7:0] REG_REFILL_AGE = 8'h14;

	// Interrupt status bits
	localparam int IRQ_FAIL = 0;
	localparam int IRQ_REFILL = 1;
	localparam int IRQ_CTX = 2;
	localparam int IRQ_W = 3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Soft page failure codes
	localparam logic [1:0] FAIL_SECT = 2'h0;
	localparam logic [1:0] FAIL_MAP = 2'h1;
	localparam logic [1:0] FAIL_STAT = 2'h2;
	localparam logic [1:0] FAIL_WPROT = 2'h3;

	// Refill sequencer, Gray from idle through fill; the step from fill back to idle flips two bits
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SECT = 3'h1,
		ST_MAP = 3'h3,
		ST_STAT = 3'h2,
		ST_FILL = 3'h6
	} ptb_state_e;

	typedef struct packed {
		logic valid;
		logic keep;
		logic writable;
		logic [TAG_W-1:0] tag;
		logic [PAGE_W-1:0] ppn;
	} ptb_entry_s;
endpackage

// ### rtl/ptb_way.sv
// One way of the translation buffer: entry array, lookup and sweep
`timescale 1ns/1ps
`default_nettype none
module ptb_way #(
	parameter int N = ptb_pkg::ENTRIES
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [ptb_pkg::IDX_W-1:0] lk_index,
	input wire logic [ptb_pkg::TAG_W-1:0] lk_tag,
	output logic hit,
	output logic [ptb_pkg::PAGE_W-1:0] hit_ppn,
	output logic hit_keep,
	output logic hit_wr,
	input wire logic wr_en,
	input wire logic [ptb_pkg::IDX_W-1:0] wr_index,
	input wire logic [ptb_pkg::TAG_W-1:0] wr_tag,
	input wire logic [ptb_pkg::PAGE_W-1:0] wr_ppn,
	input wire logic wr_keep,
	input wire logic wr_wr,
	input wire logic sweep_all,
	input wire logic sweep_nonkeep
);
	typedef struct packed {
		ptb_pkg::ptb_entry_s [N-1:0] ent;
	} ptb_way_s;

	ptb_way_s r_ff;
	ptb_way_s nxt_r;
	ptb_pkg::ptb_entry_s sel;

	// Read side is combinational so both ways answer in the lookup cycle
	always_comb begin
		sel = r_ff.ent[lk_index];
		hit = sel.valid && (sel.tag == lk_tag);
		hit_ppn = sel.ppn;
		hit_keep = sel.keep;
		hit_wr = sel.writable;
	end

	// Sweep clears valid flags only; tags stay for the keep case
	always_comb begin
		nxt_r = r_ff;
		for (int i = 0; i < N; i++) begin
			if (sweep_all) begin
				nxt_r.ent[i].valid = 1'b0;
			end else if (sweep_nonkeep && !r_ff.ent[i].keep) begin
				nxt_r.ent[i].valid = 1'b0;
			end
		end
		if (wr_en) begin
			nxt_r.ent[wr_index].valid = 1'b1;
			nxt_r.ent[wr_index].keep = wr_keep;
			nxt_r.ent[wr_index].writable = wr_wr;
			nxt_r.ent[wr_index].tag = wr_tag;
			nxt_r.ent[wr_index].ppn = wr_ppn;
		end
	end

	// State register
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end
endmodule
`default_nettype wire

// ### bench/ptb_mem_model.sv
// Memory partner answering refill reads after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module ptb_mem_model (
	input wire logic sys_clk,
	input wire logic mem_req,
	input wire logic [21:0] mem_addr,
	output logic mem_ack,
	output logic [35:0] mem_rdata,
	input wire logic [3:0] lat
);
	logic [35:0] mem [logic [21:0]];
	int wait_cnt;
	initial begin
		mem_ack = 1'b0;
		mem_rdata = '0;
		wait_cnt = 0;
	end
	// Missing words read as zero, so absent tables really fail
	always @(posedge sys_clk) begin
		mem_rdata <= ~mem_rdata;
		if (mem_ack || !mem_req) begin
			mem_ack <= 1'b0;
			wait_cnt <= 0;
		end else if (wait_cnt < lat) begin
			wait_cnt <= wait_cnt + 1;
		end else begin
			mem_ack <= 1'b1;
			mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : '0;
		end
	end
endmodule
`default_nettype wire

// ### bench/ptb_properties.sv
// Checker on the translation buffer ports
`timescale 1ns/1ps
`default_nettype none
module ptb_properties (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic lk_valid,
	input wire logic lk_ready,
	input wire logic xl_done,
	input wire logic xl_fail,
	input wire logic [1:0] xl_fail_code,
	input wire logic ctx_valid,
	input wire logic ctx_ready,
	input wire logic [ptb_pkg::WORD_W-1:0] ctx_word,
	input wire logic [2:0] cur_block,
	input wire logic [2:0] prev_block,
	input wire logic [ptb_pkg::SECT_W-1:0] prev_section,
	input wire logic [ptb_pkg::PAGE_W-1:0] process_map_base,
	input wire logic acct_update,
	input wire logic mem_req,
	input wire logic [ptb_pkg::PADDR_W-1:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [ptb_pkg::WORD_W-1:0] mem_rdata,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	wire ctx_take = ctx_valid && ctx_ready;
	wire lk_take = lk_valid && lk_ready && !ctx_take;
	wire ack = mem_req && mem_ack;
	logic [1:0] ack_cnt_ff;
	logic [1:0] nxt_ack_cnt;
	// Reads since the last take; a failing read's count is its code
	always_comb begin
		nxt_ack_cnt = ack_cnt_ff;
		if (lk_take)
			nxt_ack_cnt = 2'h0;
		else if (ack)
			nxt_ack_cnt = ack_cnt_ff + 2'h1;
	end
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			ack_cnt_ff <= 2'h0;
		else
			ack_cnt_ff <= nxt_ack_cnt;
	end
	property p_ctx_blk;
		ctx_take && ctx_word[35] |=> cur_block == $past(ctx_word[29:27])
			&& prev_block == $past(ctx_word[26:24]);
	endproperty
	a_ctx_blk: assert property (p_ctx_blk) else $error("block select wrong");
	property p_ctx_sect;
		ctx_take && ctx_word[34] |=> prev_section == $past(ctx_word[22:18]);
	endproperty
	a_ctx_sect: assert property (p_ctx_sect) else $error("previous section wrong");
	property p_ctx_base;
		ctx_take && ctx_word[33] |=> process_map_base == $past(ctx_word[12:0]);
	endproperty
	a_ctx_base: assert property (p_ctx_base) else $error("map base wrong");
	property p_base_hold;
		ctx_take && !ctx_word[33] |=> $stable(process_map_base);
	endproperty
	a_base_hold: assert property (p_base_hold) else $error("map base changed");
	property p_acct;
		ctx_take |=> acct_update == !$past(ctx_word[17]);
	endproperty
	a_acct: assert property (p_acct) else $error("accounting pulse wrong");
	property p_first_addr;
		$rose(mem_req) |-> mem_addr[8:0] >= 9'h160 && mem_addr[8:0] <= 9'h17f && !lk_ready;
	endproperty
	a_first_addr: assert property (p_first_addr) else $error("first read off table");
	property p_answer;
		lk_take |=> xl_done || mem_req;
	endproperty
	a_answer: assert property (p_answer) else $error("lookup gave no answer");
	property p_fail;
		ack && !mem_rdata[34] |=> xl_done && xl_fail && xl_fail_code == $past(ack_cnt_ff);
	endproperty
	a_fail: assert property (p_fail) else $error("soft failure missing");
	property p_fill;
		ack && ack_cnt_ff == 2'h2 && mem_rdata[34] |=>
			(!mem_req && (!xl_done || xl_fail_code == 2'h3)) ##1 (xl_done ^ $past(xl_done));
	endproperty
	a_fill: assert property (p_fill) else $error("refill not completed");
	property p_reads;
		xl_done && !xl_fail |-> ack_cnt_ff == 2'h0 || ack_cnt_ff == 2'h3;
	endproperty
	a_reads: assert property (p_reads) else $error("refill read count wrong");
	property p_bresp;
		s_axi_bvalid |=> (s_axi_bvalid == !$past(s_axi_bready))
			&& (!s_axi_bvalid || $stable(s_axi_bresp));
	endproperty
	a_bresp: assert property (p_bresp) else $error("write response dropped");
	c_keep: cover property (ctx_take && ctx_word[32]);
	c_fail: cover property (xl_done && xl_fail);
	c_fill: cover property (ack && ack_cnt_ff == 2'h2);
endmodule
bind ptb_top ptb_properties u_props (.*);
`default_nettype wire

// ### bench/test_paged_translation_buffer.sv
// Self-checking bench for the paged translation buffer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("mismatch t=%0t got %0h exp %0h", $time, g, e); end end
module test_paged_translation_buffer;
	logic sys_clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, lat;
	logic [1:0] s_axi_bresp, s_axi_rresp, xl_fail_code;
	logic irq, lk_valid, lk_ready, lk_user, lk_write, xl_done, xl_fail, xl_keep, xl_writable;
	logic [4:0] lk_section, prev_section;
	logic [8:0] lk_page;
	logic [12:0] xl_ppn, process_map_base;
	logic ctx_valid, ctx_ready, acct_update, mem_req, mem_ack;
	logic [35:0] ctx_word, mem_rdata;
	logic [2:0] cur_block, prev_block;
	logic [21:0] mem_addr;
	int error_cnt, cmp_count, rd_cnt;
	ptb_top DUT (.*);
	ptb_mem_model mem_i (.*);
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Refill reads seen by the partner
	always @(posedge sys_clk) if (mem_req && mem_ack) rd_cnt++;
	task automatic wrap_up;
		if (error_cnt == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Bus tasks end one edge after release, so the next call never collides
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		`CHK(s_axi_bresp, e)
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge sys_clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		`CHK(s_axi_rdata, d)
		`CHK(s_axi_rresp, e)
		@(posedge sys_clk);
	endtask
	// Translation; n is the expected memory read count, negative to skip
	task automatic xl(input logic u, w, input logic [4:0] s, input logic [8:0] p,
		input logic f, input logic [1:0] c, input logic [12:0] pp, input int n);
		int r0;
		r0 = rd_cnt;
		{lk_user, lk_write, lk_section, lk_page, lk_valid} <= {u, w, s, p, 1'b1};
		do @(posedge sys_clk); while (!lk_ready);
		lk_valid <= 1'b0;
		do @(posedge sys_clk); while (!xl_done);
		`CHK(xl_fail, f)
		if (f) `CHK(xl_fail_code, c)
		else `CHK(xl_ppn, pp)
		if (n >= 0) `CHK(rd_cnt - r0, n)
	endtask
	task automatic ctx(input logic [35:0] w);
		{ctx_word, ctx_valid} <= {w, 1'b1};
		do @(posedge sys_clk); while (!ctx_ready);
		ctx_valid <= 1'b0;
		@(posedge sys_clk);
		`CHK(acct_update, !w[17])
	endtask
	function automatic logic [35:0] ptr(input logic pr, wr, k, input logic [12:0] pg);
		return {1'b0, pr, 1'b0, wr, 1'b0, k, 17'h0, pg};
	endfunction
	// Section pointer, map pointer and status word for one page
	task automatic map(input logic [12:0] b, input logic [4:0] s, input logic [8:0] p,
		input logic ks, km, wr, st, input logic [12:0] pp);
		mem_i.mem[{b, 9'h160 + 9'(s)}] = ptr(1'b1, wr, ks, 13'h0100 + 13'(s));
		mem_i.mem[{13'h0100 + 13'(s), p}] = ptr(1'b1, wr, km, pp);
		mem_i.mem[{13'h0020, 9'h100 + 9'(s)}] = ptr(st, 1'b0, 1'b0, 13'h0);
	endtask
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{lk_valid, lk_user, lk_write, ctx_valid, resetn, lk_section, lk_page} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, ctx_word, lat} = '0;
		s_axi_wstrb = 4'hf;
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		wr(ptb_pkg::REG_EXEC_BASE, 32'h10, ptb_pkg::RESP_OKAY);
		wr(ptb_pkg::REG_STAT_BASE, 32'h20, ptb_pkg::RESP_OKAY);
		wr(ptb_pkg::REG_IRQ_MASK, 32'h1, ptb_pkg::RESP_OKAY);
		wr(8'h40, 32'h5, ptb_pkg::RESP_SLVERR);
		rd(ptb_pkg::REG_EXEC_BASE, 32'h10, ptb_pkg::RESP_OKAY);
		rd(8'h40, 32'h0, ptb_pkg::RESP_SLVERR);
		map(13'h0010, 5'h01, 9'h005, 1'b1, 1'b1, 1'b1, 1'b1, 13'h0a01);
		map(13'h0010, 5'h02, 9'h005, 1'b0, 1'b0, 1'b1, 1'b1, 13'h0a02);
		map(13'h0010, 5'h03, 9'h005, 1'b0, 1'b0, 1'b1, 1'b1, 13'h0a03);
		map(13'h0010, 5'h07, 9'h006, 1'b0, 1'b1, 1'b1, 1'b1, 13'h0a07);
		map(13'h0010, 5'h06, 9'h007, 1'b1, 1'b1, 1'b0, 1'b1, 13'h0a06);
		map(13'h0010, 5'h08, 9'h008, 1'b1, 1'b1, 1'b1, 1'b0, 13'h0a08);
		map(13'h0040, 5'h09, 9'h009, 1'b0, 1'b0, 1'b1, 1'b1, 13'h0a09);
		mem_i.mem[{13'h0010, 9'h165}] = ptr(1'b1, 1'b1, 1'b0, 13'h0105);
		xl(1'b0, 1'b0, 5'h01, 9'h005, 1'b0, 2'h0, 13'h0a01, 3);
		xl(1'b0, 1'b0, 5'h01, 9'h005, 1'b0, 2'h0, 13'h0a01, 0);
		lat <= 4'h3;
		xl(1'b0, 1'b0, 5'h02, 9'h005, 1'b0, 2'h0, 13'h0a02, 3);
		xl(1'b0, 1'b0, 5'h01, 9'h005, 1'b0, 2'h0, 13'h0a01, 0);
		xl(1'b0, 1'b0, 5'h03, 9'h005, 1'b0, 2'h0, 13'h0a03, 3);
		xl(1'b0, 1'b0, 5'h02, 9'h005, 1'b0, 2'h0, 13'h0a02, 0);
		xl(1'b0, 1'b0, 5'h01, 9'h005, 1'b0, 2'h0, 13'h0a01, 3);
		xl(1'b0, 1'b0, 5'h07, 9'h006, 1'b0, 2'h0, 13'h0a07, 3);
		ctx({4'hf, 2'h0, 3'h5, 3'h2, 1'b0, 5'h13, 1'b0, 4'h0, 13'h0040});
		`CHK({cur_block, prev_block}, 6'h2a)
		`CHK(prev_section, 5'h13)
		`CHK(process_map_base, 13'h0040)
		rd(ptb_pkg::REG_REFILL_AGE, 32'h40, ptb_pkg::RESP_OKAY);
		xl(1'b0, 1'b0, 5'h01, 9'h005, 1'b0, 2'h0, 13'h0a01, 0);
		`CHK({xl_keep, xl_writable}, 2'h3)
		xl(1'b0, 1'b0, 5'h07, 9'h006, 1'b0, 2'h0, 13'h0a07, 3);
		xl(1'b0, 1'b0, 5'h03, 9'h005, 1'b0, 2'h0, 13'h0a03, 3);
		xl(1'b1, 1'b0, 5'h09, 9'h009, 1'b0, 2'h0, 13'h0a09, 3);
		ctx({4'h0, 14'h0, 1'b1, 4'h0, 13'h1fff});
		`CHK({cur_block, process_map_base}, 16'ha040)
		xl(1'b0, 1'b0, 5'h01, 9'h005, 1'b0, 2'h0, 13'h0a01, 3);
		`CHK(irq, 1'b0)
		xl(1'b0, 1'b0, 5'h04, 9'h004, 1'b1, 2'h0, 13'h0, 1);
		xl(1'b0, 1'b0, 5'h05, 9'h004, 1'b1, 2'h1, 13'h0, 2);
		xl(1'b0, 1'b0, 5'h08, 9'h008, 1'b1, 2'h2, 13'h0, 3);
		xl(1'b0, 1'b1, 5'h06, 9'h007, 1'b1, 2'h3, 13'h0, 3);
		xl(1'b0, 1'b0, 5'h06, 9'h007, 1'b0, 2'h0, 13'h0a06, 3);
		xl(1'b0, 1'b1, 5'h06, 9'h007, 1'b1, 2'h3, 13'h0, 0);
		@(posedge sys_clk);
		`CHK(irq, 1'b1)
		rd(ptb_pkg::REG_IRQ_STATUS, 32'h7, ptb_pkg::RESP_OKAY);
		rd(ptb_pkg::REG_STATE, 32'h0000_4018, ptb_pkg::RESP_OKAY);
		wr(ptb_pkg::REG_IRQ_STATUS, 32'h7, ptb_pkg::RESP_OKAY);
		@(posedge sys_clk);
		`CHK(irq, 1'b0)
		rd(ptb_pkg::REG_IRQ_STATUS, 32'h0, ptb_pkg::RESP_OKAY);
		wr(ptb_pkg::REG_IRQ_MASK, 32'h0, ptb_pkg::RESP_OKAY);
		xl(1'b0, 1'b0, 5'h04, 9'h004, 1'b1, 2'h0, 13'h0, 1);
		@(posedge sys_clk);
		`CHK(irq, 1'b0)
		wrap_up();
	end
	// Hang guard, far beyond the few hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		wrap_up();
	end
endmodule
`default_nettype wire
